// ### tpg_decoder.sv
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module tpg_decoder
    import tpg_pkg::*;
#(
    parameter int POWER_ON_LIMIT = int'(POWER_ON_CYCLES),
    parameter int RAMP_PERIOD    = RAMP_DIV,
    parameter int FILTER_LEN     = FILTER_TICKS
)(
    // Clock and reset.
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Wishbone slave.
    input  wire tpg_wb_req_type  wb_i,
    output logic [31:0]          wb_dat_o,
    output logic                 wb_ack_o,
    // Carrier, mains references and inhibits.
    input  wire logic            carrier_clock_i,
    input  wire logic [2:0]      mains_ref_i,
    input  wire tpg_inhibit_type inhibit_i,
    // Gate pulses and delay steering toward the loop.
    output logic [GATES-1:0]     gate_o,
    output logic [7:0]           delay_bias_o
);

    logic                 carrier_q;
    logic                 carrier_rise;
    logic [DIV_W-1:0]     div_cnt;
    logic                 six_times_mains_clock;
    logic [2:0]           ring_counter_x;
    logic [2:0]           ring_counter_y;
    logic [5:0]           win_x;
    logic [5:0]           win_y;
    logic [GATES-1:0]     window;
    logic [2:0]           ref_f;
    logic                 ref_a_q;
    logic                 seq_reverse;
    logic                 power_on;
    logic [31:0]          power_cnt;
    logic [31:0]          ramp_cnt;
    logic                 ramp_tick;
    tpg_state_type        state;
    logic                 gating;
    logic                 gate_en;
    logic [31:0]          ctrl;
    logic                 mode2;

    // The carrier is sampled as a level; a rising edge is one step of the divider.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carrier_q <= 1'b0;
        end else begin
            carrier_q <= carrier_clock_i;
        end
    end
    assign carrier_rise = carrier_clock_i && !carrier_q;

    // Divide-by-64: its top bit is the six-times-mains clock at 1/64 of the carrier, 384/64 of mains.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= '0;
        end else if (carrier_rise) begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end
    assign six_times_mains_clock = div_cnt[HALF_BIT];

    // Ring x steps on the carrier tick that raises the top bit, ring y on the tick that drops it:
    // half a step is 30 degrees. Stepping on the tick itself moves the windows together with the
    // delayed carrier, so a window edge never splits a pulse.
    tpg_ring u_ring_x (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .step_i    (carrier_rise && div_cnt == DIV_W'((1 << HALF_BIT) - 1)),
        .reverse_i (seq_reverse),
        .step_o    (ring_counter_x),
        .window_o  (win_x)
    );
    tpg_ring u_ring_y (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .step_i    (carrier_rise && (&div_cnt)),
        .reverse_i (seq_reverse),
        .step_o    (ring_counter_y),
        .window_o  (win_y)
    );

    // Interleave the two rings so neighbouring gates are 30 degrees apart; mode two keeps
    // only the first 32 carrier pulses after each ring step, giving two 30 degree bursts.
    // The mode bit is taken over only on a carrier tick, so a mode switch never cuts a pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode2 <= 1'b0;
        end else if (carrier_rise) begin
            mode2 <= ctrl[CTRL_MODE2];
        end
    end
    generate
        for (genvar k = 0; k < RING_STEPS; k++) begin : g_gate
            assign window[2*k]   = win_x[k] && (!mode2 || six_times_mains_clock);
            assign window[2*k+1] = win_y[k] && (!mode2 || !six_times_mains_clock);
        end
    endgenerate

    // Glitch filter on each reference: a level is accepted only after it has held steady
    // for a number of carrier ticks, so a false crossing never reaches the sequence logic.
    generate
        for (genvar p = 0; p < PHASES; p++) begin : g_filt
            logic [7:0] stable_cnt;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    stable_cnt <= 8'h00;
                    ref_f[p]   <= 1'b0;
                end else if (mains_ref_i[p] == ref_f[p]) begin
                    stable_cnt <= 8'h00;
                end else if (carrier_rise) begin
                    if (stable_cnt == 8'(FILTER_LEN - 1)) begin
                        ref_f[p]   <= mains_ref_i[p];
                        stable_cnt <= 8'h00;
                    end else begin
                        stable_cnt <= stable_cnt + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // At each rising A crossing, a high B means the phases run a-c-b.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_a_q     <= 1'b0;
            seq_reverse <= 1'b0;
        end else begin
            ref_a_q <= ref_f[0];
            if (ref_f[0] && !ref_a_q) begin
                seq_reverse <= ref_f[1];
            end
        end
    end

    // Power-on hold reuses the phase-loss path; the loop needs this long to lock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_on  <= 1'b1;
            power_cnt <= 32'h0000_0000;
        end else if (power_on) begin
            if (power_cnt == 32'(POWER_ON_LIMIT - 1)) begin
                power_on <= 1'b0;
            end
            power_cnt <= power_cnt + 32'h0000_0001;
        end
    end

    // Ramp step divider.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_cnt  <= 32'h0000_0000;
            ramp_tick <= 1'b0;
        end else begin
            ramp_tick <= (ramp_cnt == 32'(RAMP_PERIOD - 1));
            ramp_cnt  <= (ramp_cnt == 32'(RAMP_PERIOD - 1)) ? 32'h0000_0000 : ramp_cnt + 32'h0000_0001;
        end
    end

    // Sequence: hold at maximum delay, soft-start down, run, soft-stop up, hold again.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_HOLD;
        end else begin
            unique case (state)
                ST_HOLD: begin
                    if (!power_on && !inhibit_i.phase_loss_flag && inhibit_i.soft_stop_inhibit_n) begin
                        state <= ST_RAMP;
                    end
                end
                ST_RAMP, ST_RUN: begin
                    if (power_on || inhibit_i.phase_loss_flag) begin
                        state <= ST_HOLD;
                    end else if (!inhibit_i.soft_stop_inhibit_n) begin
                        state <= ST_STOP;
                    end else if (state == ST_RAMP && delay_bias_o == DELAY_MIN) begin
                        state <= ST_RUN;
                    end
                end
                ST_STOP: begin
                    if (inhibit_i.phase_loss_flag || delay_bias_o == DELAY_MAX) begin
                        state <= ST_HOLD;
                    end
                end
            endcase
        end
    end

    // Delay bias: held at maximum in ST_HOLD, decays by a fixed fraction per step
    // during soft-start, and climbs back to maximum during soft-stop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_bias_o <= DELAY_MAX;
        end else if (state == ST_HOLD) begin
            delay_bias_o <= DELAY_MAX;
        end else if (ramp_tick && state == ST_RAMP && delay_bias_o != DELAY_MIN) begin
            delay_bias_o <= delay_bias_o - (delay_bias_o >> RAMP_SHIFT) - 8'h01;
        end else if (ramp_tick && state == ST_STOP && delay_bias_o != DELAY_MAX) begin
            delay_bias_o <= delay_bias_o + ((DELAY_MAX - delay_bias_o) >> RAMP_SHIFT) + 8'h01;
        end
    end

    // Turn-off is immediate; turn-on waits for a carrier rise so no first pulse is cut.
    assign gating = (state != ST_HOLD) && inhibit_i.instant_inhibit_n && !inhibit_i.phase_loss_flag;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_en <= 1'b0;
        end else if (!gating) begin
            gate_en <= 1'b0;
        end else if (carrier_rise) begin
            gate_en <= 1'b1;
        end
    end

    // Window and delayed carrier change on the same edge, so only a turn-off can cut a pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_o <= '0;
        end else begin
            gate_o <= window & {GATES{carrier_q && gate_en && gating}};
        end
    end

    // Wishbone: one wait state, ack drops the cycle after it is given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl     <= CTRL_RESET;
        end else begin
            wb_ack_o <= wb_i.cyc && wb_i.stb && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_i.cyc && wb_i.stb && !wb_ack_o) begin
                if (wb_i.we && wb_i.adr == REG_CTRL && wb_i.sel[0]) begin
                    ctrl[7:0] <= wb_i.dat[7:0];
                end
                unique case (wb_i.adr)
                    REG_CTRL:     wb_dat_o <= ctrl;
                    REG_STATUS:   wb_dat_o <= {24'h00_0000, gate_en, seq_reverse, power_on,
                                               inhibit_i.phase_loss_flag, 2'(state), 2'h0};
                    REG_POSITION: wb_dat_o <= {18'h0_0000, ring_counter_y, 1'b0, ring_counter_x,
                                               1'b0, div_cnt};
                    REG_DELAY:    wb_dat_o <= {24'h00_0000, delay_bias_o};
                    default:      wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks.
    sequence s_gate_off;
        gate_o == '0;
    endsequence

    property p_instant;
        @(posedge clk_i) disable iff (rst_i) !inhibit_i.instant_inhibit_n |=> s_gate_off;
    endproperty
    a_instant: assert property (p_instant) else $error("gate active under instant inhibit");

    property p_phase_loss;
        @(posedge clk_i) disable iff (rst_i) inhibit_i.phase_loss_flag |=> s_gate_off;
    endproperty
    a_phase_loss: assert property (p_phase_loss) else $error("gate active under phase loss");

    property p_power_on;
        @(posedge clk_i) disable iff (rst_i) power_on |=> s_gate_off;
    endproperty
    a_power_on: assert property (p_power_on) else $error("gate active during power-on hold");

    property p_carrier;
        @(posedge clk_i) disable iff (rst_i) gate_o != '0 |-> $past(carrier_q);
    endproperty
    a_carrier: assert property (p_carrier) else $error("gate high without carrier");

    property p_windows;
        @(posedge clk_i) disable iff (rst_i) !mode2 |-> $countones(window) == 2 * WIN_STEPS;
    endproperty
    a_windows: assert property (p_windows) else $error("wrong number of open windows");

    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
            $past(state) == ST_HOLD && state == ST_RAMP |-> delay_bias_o == DELAY_MAX;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not at maximum delay");

    property p_stop;
        @(posedge clk_i) disable iff (rst_i)
            $past(state) == ST_STOP && state == ST_HOLD && !$past(inhibit_i.phase_loss_flag)
            |-> $past(delay_bias_o) == DELAY_MAX;
    endproperty
    a_stop: assert property (p_stop) else $error("soft stop inhibited before maximum");

    property p_divider;
        @(posedge clk_i) disable iff (rst_i) carrier_rise |=> div_cnt == $past(div_cnt) + DIV_W'(1);
    endproperty
    a_divider: assert property (p_divider) else $error("carrier divider missed a step");

    property p_burst2;
        @(posedge clk_i) disable iff (rst_i) $past(mode2) && gate_o[0] |-> $past(six_times_mains_clock);
    endproperty
    a_burst2: assert property (p_burst2) else $error("mode two burst outside its half");

endmodule // tpg_decoder

// ### tpg_pkg.sv
package tpg_pkg;

    // Gate and ring geometry.
    localparam int GATES         = 12;
    localparam int PHASES        = 3;
    localparam int RING_STEPS    = 6;
    localparam int DIV_W         = 6;     // Divide-by-64 carrier counter.
    localparam int HALF_BIT      = 5;     // Counter bit that is the six-times-mains clock.
    localparam int WIN_STEPS     = 2;     // A 120 degree window spans two 60 degree steps.

    // Timing: power-on hold time and the clock rate it is counted at.
    localparam longint CLK_HZ          = 125_000_000;
    localparam longint POWER_ON_MS     = 20;
    localparam longint POWER_ON_CYCLES = (POWER_ON_MS * CLK_HZ + 999) / 1000;

    // Soft ramp and reference filter defaults.
    localparam int         RAMP_DIV     = 1024;   // Clocks between ramp steps.
    localparam int         RAMP_SHIFT   = 4;      // Exponential decay factor 1/16 per step.
    localparam int         FILTER_TICKS = 4;      // Carrier ticks a reference must be stable.
    localparam logic [7:0] DELAY_MAX    = 8'hFF;
    localparam logic [7:0] DELAY_MIN    = 8'h00;

    // Register map, byte addresses on the Wishbone bus.
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_POSITION = 8'h08;
    localparam logic [7:0] REG_DELAY    = 8'h0C;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam int          CTRL_MODE2  = 0;

    // Start-up and shutdown sequence.
    typedef enum logic [1:0] {ST_HOLD, ST_RAMP, ST_RUN, ST_STOP} tpg_state_type;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tpg_wb_req_type;

    // Inhibit inputs, all active low except the phase-loss flag.
    typedef struct packed {
        logic instant_inhibit_n;
        logic soft_stop_inhibit_n;
        logic phase_loss_flag;
    } tpg_inhibit_type;

endpackage

// ### tpg_ring.sv
`timescale 1ns/1ps
module tpg_ring
    import tpg_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Step control.
    input  wire logic       step_i,
    input  wire logic       reverse_i,
    // Ring position and decoded 120 degree windows.
    output logic [2:0]      step_o,
    output logic [5:0]      window_o
);

    // Divide-by-6 ring; reversing the direction reverses the firing order.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_o <= 3'h0;
        end else if (step_i) begin
            if (reverse_i) begin
                step_o <= (step_o == 3'h0) ? 3'(RING_STEPS - 1) : step_o - 3'h1;
            end else begin
                step_o <= (step_o == 3'(RING_STEPS - 1)) ? 3'h0 : step_o + 3'h1;
            end
        end
    end

    // Window k is open for steps k and k+1: 120 degrees, neighbours 60 degrees apart.
    generate
        for (genvar k = 0; k < RING_STEPS; k++) begin : g_win
            assign window_o[k] = (step_o == 3'(k)) || (step_o == 3'((k + 1) % RING_STEPS));
        end
    endgenerate

    property p_ring_range;
        @(posedge clk_i) disable iff (rst_i) step_o < 3'(RING_STEPS);
    endproperty
    a_ring_range: assert property (p_ring_range) else $error("ring step out of range");

    property p_ring_hold;
        @(posedge clk_i) disable iff (rst_i) !step_i |=> $stable(step_o);
    endproperty
    a_ring_hold: assert property (p_ring_hold) else $error("ring moved without a step");

endmodule // tpg_ring

// ### tpg_amp_model.sv
`timescale 1ns/1ps
// Gate amplifier model: counts the pulses of each burst and checks every pulse width.
module tpg_amp_model
    import tpg_pkg::*;
#(
    parameter int PULSE_W = 2,
    parameter int GAP_MAX = 8
)(
    // Clock.
    input  wire logic              clk_i,
    // Gate trains from the decoder.
    input  wire logic [GATES-1:0]  gate_i,
    // Last finished burst of each gate and a count of malformed pulses.
    output logic [GATES-1:0][8:0]  count_o,
    output logic [GATES-1:0][31:0] start_o,
    output logic [31:0]            bad_o
);
    logic [31:0]            now = 32'h0;
    logic [GATES-1:0][8:0]  cnt = '0;
    logic [GATES-1:0][7:0]  gap = '0;
    logic [GATES-1:0][7:0]  wid = '0;
    logic [GATES-1:0][31:0] t0  = '0;

    initial begin
        count_o = '0;
        start_o = '0;
        bad_o   = '0;
    end

    // A gap longer than a few carrier periods closes a burst. A pulse cut short at turn-off is
    // tolerated, but a stretched pulse or a short first pulse is a fault of the decoder.
    always @(posedge clk_i) begin
        now <= now + 32'h1;
        for (int g = 0; g < GATES; g++) begin
            if (gate_i[g]) begin
                wid[g] <= wid[g] + 8'h1;
                gap[g] <= 8'h0;
                if (wid[g] == 8'h0) begin
                    cnt[g] <= cnt[g] + 9'h1;
                    if (cnt[g] == 9'h0) t0[g] <= now;
                end
            end else begin
                wid[g] <= 8'h0;
                if (gap[g] != 8'hFF) gap[g] <= gap[g] + 8'h1;
                if (wid[g] > PULSE_W || (wid[g] != 8'h0 && cnt[g] == 9'h1 && wid[g] != PULSE_W)) begin
                    bad_o <= bad_o + 32'h1;
                end
                if (gap[g] == GAP_MAX && cnt[g] != 9'h0) begin
                    count_o[g] <= cnt[g];
                    start_o[g] <= t0[g];
                    cnt[g]     <= 9'h0;
                end
            end
        end
    end
endmodule // tpg_amp_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tpg_pkg::*;
    localparam int PER = RING_STEPS * (1 << DIV_W) * 4;
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    tpg_wb_req_type         wb_r  = '0;
    tpg_inhibit_type        inh   = 3'b110;
    logic                   car   = 1'b0;
    logic                   rev   = 1'b0;
    logic [2:0]             mains = 3'h0;
    logic [1:0]             sub   = 2'h0;
    int                     tick  = 0;
    logic [31:0]            wb_dat;
    logic                   wb_ack;
    logic [GATES-1:0]       gate;
    logic [7:0]             dly;
    logic [GATES-1:0][8:0]  cnt;
    logic [GATES-1:0][31:0] st;
    logic [31:0]            bad;
    int                     fail_count = 0;
    int                     n_checks = 0;

    tpg_decoder #(.POWER_ON_LIMIT(100), .RAMP_PERIOD(4), .FILTER_LEN(4)) tpg_decoder_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_r), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
        .carrier_clock_i(car), .mains_ref_i(mains), .inhibit_i(inh), .gate_o(gate), .delay_bias_o(dly));
    tpg_amp_model tpg_amp_model_i (.clk_i(clk_i), .gate_i(gate), .count_o(cnt), .start_o(st), .bad_o(bad));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic mph(input int t, input int sh);
        return ((t + 384 - sh) % 384) < 192;
    endfunction

    // Carrier of four clocks a tick; mains references locked to it. A one-tick dip on A at tick
    // 100 is shorter than the reference filter and must change nothing.
    always @(posedge clk_i) begin
        sub  <= sub + 2'h1;
        car  <= ~sub[1];
        if (sub == 2'h3) tick <= (tick + 1) % 384;
        mains <= {mph(tick, rev ? 128 : 256), mph(tick, rev ? 256 : 128), mph(tick, 0) ^ (tick == 100)};
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic stall();
        fail_count++;
        $display("[ERR] %0t wait timed out", $time);
        report_and_stop();
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int   n;
        logic ok;
        n = 0;
        wb_r <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        q = wb_dat;
        ok = (wb_ack === 1'b1);
        wb_r <= '0;
        @(posedge clk_i);
        if (!ok) stall();
    endtask

    task automatic quiet(input int n, output int hits);
        hits = 0;
        repeat (n) begin
            @(posedge clk_i);
            if (gate !== 12'h0) hits++;
        end
    endtask

    task automatic until_dly(input logic [7:0] v, output logic saw);
        int n;
        saw = 1'b0;
        n = 0;
        while (dly !== v && n < 4000) begin
            @(posedge clk_i);
            if (gate !== 12'h0 && dly !== v) saw = 1'b1;
            n++;
        end
        if (dly !== v) stall();
    endtask

    task automatic until_gate(input int lim);
        int n;
        n = 0;
        while (gate === 12'h0 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (gate === 12'h0) stall();
    endtask

    function automatic logic [31:0] md(input logic [31:0] a, input logic [31:0] b);
        return (a - b + 32'd1536000) % PER;
    endfunction

    // Reset values, register map and the power-on hold.
    task automatic s_reset();
        logic [31:0] q;
        int          h;
        chk(gate, 32'h0);
        chk(dly, 32'hFF);
        wb(1'b0, REG_CTRL, 32'h0, q);
        chk(q, CTRL_RESET);
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(q[3:2], 32'h0);
        chk(q[5], 32'h1);
        quiet(80, h);
        chk(h, 32'h0);
    endtask

    // Gating starts at the delay limit and decays to the minimum while firing.
    task automatic s_start();
        logic [31:0] q;
        logic        s;
        until_dly(8'h00, s);
        chk(s, 32'h1);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(q[3:2], 32'h2);
    endtask

    // Burst lengths of all twelve gates and, in mode one, their thirty degree spacing.
    task automatic s_mode(input logic two);
        logic [31:0] q;
        wb(1'b1, REG_CTRL, {31'h0, two}, q);
        wb(1'b0, REG_CTRL, 32'h0, q);
        chk(q, {31'h0, two});
        repeat (4 * PER) @(posedge clk_i);
        for (int g = 0; g < GATES; g++) begin
            chk(cnt[g], two ? 32'd32 : 32'd128);
            if (!two) chk(md(st[g], st[0]), g * PER / 12);
        end
        chk(bad, 32'h0);
    endtask

    // Instant inhibit stops gating in mid-burst and restarts with a whole pulse.
    task automatic s_instant();
        int h;
        until_gate(40);
        inh.instant_inhibit_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        quiet(500, h);
        chk(h, 32'h0);
        inh.instant_inhibit_n <= 1'b1;
        until_gate(12);
        repeat (2 * PER) @(posedge clk_i);
        chk(bad, 32'h0);
    endtask

    // Phase loss blocks gating and forces the delay limit; clearing it soft-starts.
    task automatic s_ploss();
        logic [31:0] q;
        logic        s;
        int          h;
        inh.phase_loss_flag <= 1'b1;
        repeat (3) @(posedge clk_i);
        quiet(300, h);
        chk(h, 32'h0);
        chk(dly, 32'hFF);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(q[4], 32'h1);
        inh.phase_loss_flag <= 1'b0;
        until_dly(8'h00, s);
        chk(s, 32'h1);
    endtask

    // Soft stop ramps to the limit while firing, then stops; release soft-starts.
    task automatic s_soft();
        logic s;
        int   h;
        inh.soft_stop_inhibit_n <= 1'b0;
        until_dly(8'hFF, s);
        chk(s, 32'h1);
        repeat (4) @(posedge clk_i);
        quiet(300, h);
        chk(h, 32'h0);
        inh.soft_stop_inhibit_n <= 1'b1;
        until_dly(8'h00, s);
        chk(s, 32'h1);
    endtask

    // A reversed mains sequence reverses the firing order.
    task automatic s_reverse();
        logic [31:0] q;
        rev <= 1'b1;
        repeat (5 * PER) @(posedge clk_i);
        chk(md(st[2], st[0]), PER * 10 / 12);
        chk(md(st[4], st[0]), PER * 8 / 12);
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(q[6], 32'h1);
    endtask

    // Main sequence; both inhibits stay high unless a scenario drops one.
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        s_reset();
        s_start();
        s_mode(1'b0);
        s_mode(1'b1);
        s_mode(1'b0);
        s_instant();
        s_ploss();
        s_soft();
        s_reverse();
        report_and_stop();
    end
endmodule // tb_top
